// ---- rtl/fsdw_top.sv ----
// Dual watchdog of the fieldbus slave controller with its settings registers.
`timescale 1ns/1ps
`default_nettype none
`include "fsdw_defs.svh"
module fsdw_top #(
   parameter int                   OUT_W      = 8,
   parameter logic [OUT_W-1:0]     SAFE_VALUE = '0
) (
   // Clock and reset
   input  wire logic               sys_clk_in,
   input  wire logic               rst_in,
   // Register access from the bus side
   input  wire logic               reg_wr_in,
   input  wire logic               reg_rd_in,
   input  wire logic [15:0]        reg_addr_in,
   input  wire fsdw_pkg::fsdw_word_t reg_wdata_in,
   output fsdw_pkg::fsdw_word_t    reg_rdata_out,
   // Traffic events
   input  wire logic               bus_pd_exchange_in,
   input  wire logic               local_access_in,
   // Communication state, passed through untouched
   input  wire logic [3:0]         comm_state_in,
   output logic [3:0]              comm_state_out,
   // Process outputs
   input  wire logic [OUT_W-1:0]   app_data_in,
   output logic [OUT_W-1:0]        out_data_out,
   // Status
   output logic                    bus_wd_expired_out,
   output logic                    local_wd_expired_out
);
   import fsdw_pkg::*;

   fsdw_word_t    div_q;
   fsdw_word_t    div_d;
   fsdw_word_t    local_time_q;
   fsdw_word_t    local_time_d;
   fsdw_word_t    bus_time_q;
   fsdw_word_t    bus_time_d;
   fsdw_word_t    rdata_q;
   fsdw_word_t    rdata_d;
   logic [OUT_W-1:0] out_q;
   logic [OUT_W-1:0] out_d;
   logic [3:0]    state_q;
   logic          bus_exp;
   logic          local_exp;
   fsdw_reg_sel_t sel;

   function automatic fsdw_reg_sel_t decode(input logic [15:0] addr);
      case (addr)
         `FSDW_OFS_TICK_DIVIDER: decode = FSDW_SEL_DIVIDER;
         `FSDW_OFS_LOCAL_TIME:   decode = FSDW_SEL_LOCAL;
         `FSDW_OFS_BUS_TIME:     decode = FSDW_SEL_BUS;
         `FSDW_OFS_STATUS:       decode = FSDW_SEL_STATUS;
         default:                decode = FSDW_SEL_NONE;
      endcase
   endfunction : decode

   // Settings only change when the master writes them; a skipped download
   // simply leaves the held values in place.
   always_comb begin
      sel          = decode(reg_addr_in);
      div_d        = div_q;
      local_time_d = local_time_q;
      bus_time_d   = bus_time_q;
      rdata_d      = rdata_q;
      if (reg_wr_in) begin
         case (sel)
            FSDW_SEL_DIVIDER: div_d        = reg_wdata_in;
            FSDW_SEL_LOCAL:   local_time_d = reg_wdata_in;
            FSDW_SEL_BUS:     bus_time_d   = reg_wdata_in;
            default:          div_d        = div_q;
         endcase
      end
      if (reg_rd_in) begin
         case (sel)
            FSDW_SEL_DIVIDER: rdata_d = div_q;
            FSDW_SEL_LOCAL:   rdata_d = local_time_q;
            FSDW_SEL_BUS:     rdata_d = bus_time_q;
            FSDW_SEL_STATUS:  rdata_d = {14'h0000, local_exp, bus_exp};
            default:          rdata_d = 16'h0000;
         endcase
      end
      out_d = (bus_exp || local_exp) ? SAFE_VALUE : app_data_in;
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         div_q        <= `FSDW_RST_TICK_DIVIDER;
         local_time_q <= `FSDW_RST_LOCAL_TIME;
         bus_time_q   <= `FSDW_RST_BUS_TIME;
         rdata_q      <= 16'h0000;
         out_q        <= SAFE_VALUE;
         state_q      <= 4'h0;
      end else begin
         div_q        <= div_d;
         local_time_q <= local_time_d;
         bus_time_q   <= bus_time_d;
         rdata_q      <= rdata_d;
         out_q        <= out_d;
         state_q      <= comm_state_in;
      end
   end

   fsdw_timer u_bus_wd (
      .sys_clk_in  (sys_clk_in),
      .rst_in      (rst_in),
      .div_in      (div_q),
      .time_in     (bus_time_q),
      .restart_in  (bus_pd_exchange_in),
      .expired_out (bus_exp)
   );

   fsdw_timer u_local_wd (
      .sys_clk_in  (sys_clk_in),
      .rst_in      (rst_in),
      .div_in      (div_q),
      .time_in     (local_time_q),
      .restart_in  (local_access_in),
      .expired_out (local_exp)
   );

   assign reg_rdata_out        = rdata_q;
   assign out_data_out         = out_q;
   assign comm_state_out       = state_q;
   assign bus_wd_expired_out   = bus_exp;
   assign local_wd_expired_out = local_exp;
endmodule : fsdw_top
`default_nettype wire

// ---- rtl/fsdw_defs.svh ----
// Register offsets, reset values and timing constants of the dual watchdog.
`ifndef FSDW_DEFS_SVH
`define FSDW_DEFS_SVH
`define FSDW_OFS_TICK_DIVIDER   16'h0400
`define FSDW_OFS_LOCAL_TIME     16'h0410
`define FSDW_OFS_BUS_TIME       16'h0420
`define FSDW_OFS_STATUS         16'h0440
`define FSDW_RST_TICK_DIVIDER   16'h09C2
`define FSDW_RST_LOCAL_TIME     16'h03E8
`define FSDW_RST_BUS_TIME       16'h03E8
`define FSDW_BASE_TICK_NS       40
`define FSDW_CLK_PERIOD_NS      100
`define FSDW_TICK_EXTRA         2
`endif

// ---- rtl/fsdw_pkg.sv ----
// Types shared by the dual watchdog design files.
package fsdw_pkg;
   typedef enum logic [2:0] {
      FSDW_SEL_NONE,
      FSDW_SEL_DIVIDER,
      FSDW_SEL_LOCAL,
      FSDW_SEL_BUS,
      FSDW_SEL_STATUS
   } fsdw_reg_sel_t;
   typedef logic [15:0] fsdw_word_t;
endpackage : fsdw_pkg

// ---- rtl/fsdw_timer.sv ----
// One watchdog: base-tick prescaler and a timeout counter.
`timescale 1ns/1ps
`default_nettype none
`include "fsdw_defs.svh"
module fsdw_timer (
   // Clock and reset
   input  wire logic              sys_clk_in,
   input  wire logic              rst_in,
   // Settings
   input  wire fsdw_pkg::fsdw_word_t div_in,
   input  wire fsdw_pkg::fsdw_word_t time_in,
   // Traffic and result
   input  wire logic              restart_in,
   output logic                   expired_out
);
   import fsdw_pkg::*;
   localparam logic [23:0] STEP_NS = 24'(`FSDW_CLK_PERIOD_NS);
   localparam logic [23:0] BASE_NS = 24'(`FSDW_BASE_TICK_NS);
   localparam logic [23:0] EXTRA   = 24'(`FSDW_TICK_EXTRA);

   logic [23:0] acc_q;
   logic [23:0] acc_d;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic        exp_q;
   logic        exp_d;
   logic [23:0] period;
   logic [23:0] acc_sum;
   logic        tick;

   // The clock is slower than the base tick, so elapsed time is kept in
   // nanoseconds; this keeps the tick length exact on average whenever div_in is 1 or more.
   always_comb begin
      period  = ({8'h00, div_in} + EXTRA) * BASE_NS;
      acc_sum = acc_q + STEP_NS;
      tick    = (acc_sum >= period);
      acc_d   = tick ? (acc_sum - period) : acc_sum;
      cnt_d   = cnt_q;
      exp_d   = exp_q;
      if (time_in == 16'h0000) begin
         acc_d = 24'h000000;
         cnt_d = 16'h0000;
         exp_d = 1'b0;
      end else if (restart_in) begin
         acc_d = 24'h000000;
         cnt_d = 16'h0000;
         exp_d = 1'b0;
      end else if (tick && !exp_q) begin
         cnt_d = cnt_q + 16'h0001;
         if (cnt_d >= time_in) begin
            exp_d = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         acc_q <= 24'h000000;
         cnt_q <= 16'h0000;
         exp_q <= 1'b0;
      end else begin
         acc_q <= acc_d;
         cnt_q <= cnt_d;
         exp_q <= exp_d;
      end
   end

   assign expired_out = exp_q;
endmodule : fsdw_timer
`default_nettype wire

// ---- verification/fsdw_top_properties.sv ----
// Port assertions of the dual watchdog.
`timescale 1ns/1ps
`default_nettype none
module fsdw_checker #(
   parameter int               OUT_W      = 8,
   parameter logic [OUT_W-1:0] SAFE_VALUE = '0
) (
   // Clock, reset and register bus
   input wire logic                 sys_clk_in,
   input wire logic                 rst_in,
   input wire logic                 reg_wr_in,
   input wire logic                 reg_rd_in,
   input wire logic [15:0]          reg_addr_in,
   input wire fsdw_pkg::fsdw_word_t reg_rdata_out,
   // Traffic, state and outputs
   input wire logic                 bus_pd_exchange_in,
   input wire logic                 local_access_in,
   input wire logic [3:0]           comm_state_in,
   input wire logic [3:0]           comm_state_out,
   input wire logic [OUT_W-1:0]     app_data_in,
   input wire logic [OUT_W-1:0]     out_data_out,
   input wire logic                 bus_wd_expired_out,
   input wire logic                 local_wd_expired_out
);
   import fsdw_pkg::*;
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   logic any_exp;
   assign any_exp = bus_wd_expired_out | local_wd_expired_out;
   a_safe_on_expiry: assert property (any_exp |=> out_data_out == SAFE_VALUE)
      else $error("output not safe");
   a_data_passes: assert property (!any_exp |=> out_data_out == $past(app_data_in))
      else $error("output data lost");
   a_state_untouched: assert property (1'b1 |=> comm_state_out == $past(comm_state_in))
      else $error("state altered");
   a_bus_stays_fired: assert property (bus_wd_expired_out && !bus_pd_exchange_in && !reg_wr_in
      |=> bus_wd_expired_out)
      else $error("bus expiry dropped");
   a_bus_restart_clears: assert property (bus_pd_exchange_in |=> !bus_wd_expired_out)
      else $error("bus restart ignored");
   a_local_restart_clears: assert property (local_access_in |=> !local_wd_expired_out)
      else $error("local restart ignored");
   a_bus_fire_idle: assert property ($rose(bus_wd_expired_out) |-> !$past(bus_pd_exchange_in))
      else $error("bus fired after traffic");
   a_unmapped_zero: assert property (reg_rd_in && reg_addr_in == 16'h0404
      |=> reg_rdata_out == 16'h0000)
      else $error("unmapped read not zero");
endmodule : fsdw_checker
bind fsdw_top fsdw_checker #(.OUT_W(OUT_W), .SAFE_VALUE(SAFE_VALUE)) u_chk (.sys_clk_in, .rst_in,
   .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_rdata_out, .bus_pd_exchange_in, .local_access_in,
   .comm_state_in, .comm_state_out, .app_data_in, .out_data_out, .bus_wd_expired_out,
   .local_wd_expired_out);
`default_nettype wire

// ---- verification/fsdw_far_end.sv ----
// Far-end traffic source: bus exchanges and local interface accesses.
`timescale 1ns/1ps
`default_nettype none
module fsdw_far_end (
   // Clock and event spacing, zero meaning silence
   input  wire logic       sys_clk_in,
   input  wire logic [7:0] bus_gap_in,
   input  wire logic [7:0] local_gap_in,
   // Events
   output logic            bus_pd_out,
   output logic            local_acc_out
);
   logic [7:0] bus_cnt_q = 8'h00;
   logic [7:0] loc_cnt_q = 8'h00;
   always @(posedge sys_clk_in) begin
      bus_cnt_q <= (bus_cnt_q >= bus_gap_in) ? 8'h00 : bus_cnt_q + 8'h01;
      loc_cnt_q <= (loc_cnt_q >= local_gap_in) ? 8'h00 : loc_cnt_q + 8'h01;
   end
   assign bus_pd_out = (bus_gap_in != 8'h00) && (bus_cnt_q == 8'h00);
   assign local_acc_out = (local_gap_in != 8'h00) && (loc_cnt_q == 8'h00);
endmodule : fsdw_far_end
`default_nettype wire

// ---- verification/fsdw_top_tb.sv ----
// Self-checking bench of the dual watchdog.
`timescale 1ns/1ps
`default_nettype none
module fsdw_top_tb;
   import fsdw_pkg::*;
   logic sys_clk_in = 1'b0, rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0, rd_q = 1'b0;
   logic [15:0] reg_addr_in = 16'h0000;
   fsdw_word_t reg_wdata_in = 16'h0000, reg_rdata_out, t;
   logic [3:0] comm_state_in = 4'h5, comm_state_out;
   logic [7:0] app_data_in = 8'h00, out_data_out, bgap = 8'h00, lgap = 8'h00;
   logic bus_pd_exchange_in, local_access_in, bus_wd_expired_out, local_wd_expired_out;
   fsdw_word_t exp_q[$];
   int error_cnt = 0, checked = 0, cyc = 0, seed = 54432;
   always #50 sys_clk_in = ~sys_clk_in;
   fsdw_far_end u_far (.sys_clk_in, .bus_gap_in(bgap), .local_gap_in(lgap),
      .bus_pd_out(bus_pd_exchange_in), .local_acc_out(local_access_in));
   fsdw_top DUT (.sys_clk_in, .rst_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in,
      .reg_rdata_out, .bus_pd_exchange_in, .local_access_in, .comm_state_in, .comm_state_out,
      .app_data_in, .out_data_out, .bus_wd_expired_out, .local_wd_expired_out);
   task chk(input fsdw_word_t got, input fsdw_word_t exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task wrap_up;
      $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   task wr(input logic [15:0] a, input fsdw_word_t d);
      @(posedge sys_clk_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge sys_clk_in);
      reg_wr_in <= 1'b0;
   endtask : wr
   task rd(input logic [15:0] a, input fsdw_word_t e);
      @(posedge sys_clk_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      exp_q.push_back(e);
      @(posedge sys_clk_in);
      reg_rd_in <= 1'b0;
   endtask : rd
   // Read data stands from the edge that samples the read, so it is compared one edge later.
   always @(posedge sys_clk_in) begin
      cyc <= cyc + 1;
      app_data_in <= 8'($random(seed));
      rd_q <= reg_rd_in;
      if (rd_q) chk(reg_rdata_out, exp_q.pop_front());
      if (cyc == 2000) begin
         error_cnt++;
         wrap_up();
      end
   end
   initial begin
      repeat (10) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      rd(16'h0400, 16'h09C2);
      rd(16'h0420, 16'h03E8);
      rd(16'h0410, 16'h03E8);
      rd(16'h0404, 16'h0000);
      $display("Test reset values done");
      t = 16'h0003 + 16'($random(seed) & 7);
      wr(16'h0410, 16'hFFFF);
      rd(16'h0410, 16'hFFFF);
      wr(16'h0400, 16'h0000);
      wr(16'h0410, 16'h0000);
      wr(16'h0420, t);
      rd(16'h0420, t);
      bgap <= 8'h01;
      repeat (40) @(posedge sys_clk_in);
      rd(16'h0440, 16'h0000);
      bgap <= 8'h00;
      repeat (int'(t) + 20) @(posedge sys_clk_in);
      rd(16'h0440, 16'h0001);
      chk({8'h00, out_data_out}, 16'h0000);
      chk({12'h000, comm_state_out}, 16'h0005);
      rd(16'h0440, 16'h0001);
      bgap <= 8'h01;
      repeat (4) @(posedge sys_clk_in);
      rd(16'h0440, 16'h0000);
      wr(16'h0410, 16'h0004);
      repeat (30) @(posedge sys_clk_in);
      rd(16'h0440, 16'h0002);
      lgap <= 8'h01;
      bgap <= 8'h00;
      wr(16'h0420, 16'h0000);
      repeat (40) @(posedge sys_clk_in);
      rd(16'h0440, 16'h0000);
      $display("Test watchdogs done");
      repeat (2) @(posedge sys_clk_in);
      wrap_up();
   end
endmodule : fsdw_top_tb
`default_nettype wire
